// file: logic/bprfsm_pkg.sv
// Purpose: Shared constants and types for the backplane replier transfer machine.
// Assumes: All bus lines are sampled on clk_i, the shared bus clock; active-low lines as levels.
// Behaviour
// - Idle moves to decode on request phase
// - Match only when address owned by replier
// - No match in decode returns idle
// - Match, not ready: enter handshake wait
// - Match and ready: enter handshake directly
// - Single-clock decode aborts on end handshake
// - Handshake wait drives SC4..SC8 high
// - Wait advances to handshake when ready
// - Handshake drives SC4 low, read data, errors, parity
// - Faults only in handshake, once per transfer
// - Data and error lines stable in handshake
// - After fault, hold handshake until SC2 low
// - Requestor done, not last, not ready: wait
// - SC2 low in handshake returns idle
// - Requestor done and ready again: stay
// - Ready meaning differs for reads and writes
// - Bus error or timeout aborts cycle
// - Exception holds machine in idle
// - No transfer until three clocks after exception
package bprfsm_pkg;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam logic [1:0] QUIET_CLKS = 2'h3; // Clocks after exception before a cycle
	localparam logic [31:0] BASE_DEF = 32'h0000_0000;
	localparam logic [31:0] MASK_DEF = 32'hffff_0000;
	localparam logic [2:0] ERR_NONE = 3'h7; // Active-low error lines idle

	// Transfer states, Gray along idle-decode-wait-handshake
	typedef enum logic [1:0] {
		BPR_IDLE = 2'h0,
		BPR_DECODE = 2'h1,
		BPR_HSWAIT = 2'h3,
		BPR_HSHAKE = 2'h2
	} bprfsm_state_t;

	// Control lines as seen on the backplane (active low)
	typedef struct packed {
		logic sc0_b;
		logic sc2_b;
		logic sc3_b;
		logic sc4_b;
		logic rd_nwr; // Read when high, latched from request control
	} bprfsm_ctl_t;

	// Replier-driven lines
	typedef struct packed {
		logic sc4_b;
		logic [2:0] err_b; // SC7..SC5
		logic sc8_b;
		logic ctl_oe;
		logic [DATA_W-1:0] ad_b;
		logic ad_oe;
	} bprfsm_drv_t;
endpackage : bprfsm_pkg

// file: logic/bprfsm_fifo.sv
// Purpose: Parameterised valid/ready FIFO holding transfer words.
// Assumes: One clock; push and pop may occur in the same cycle.
// Notes: Full and empty come from registered count.
`timescale 1ns/1ps
module bprfsm_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic in_rdy_r;
	logic out_vld_r;
	logic push;
	logic pop;

	// Flags are registered from the next count so both ports see flop outputs
	assign in_ready_o = in_rdy_r;
	assign out_valid_o = out_vld_r;
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem[rp_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Storage array needs no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_rdy_r <= 1'b1;
			out_vld_r <= 1'b0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			// Back-pressure is honest: no push once the count reaches depth
			in_rdy_r <= (cnt_nxt != (AW+1)'(D));
			out_vld_r <= (cnt_nxt != '0);
		end
	end
endmodule : bprfsm_fifo

// file: logic/bprfsm_replier.sv
// Purpose: Replying-agent transfer state machine on the parallel backplane.
// Assumes: Bus lines arrive synchronous to clk_i; write data is posted into
//   a FIFO and read data is taken from a FIFO filled by the user side.
// Notes: Outputs are registered; tri-state lines come as value plus enable.
`timescale 1ns/1ps
module bprfsm_replier (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [31:0] addr_base_i,
	input wire logic [31:0] addr_mask_i,
	input wire logic sc0_b_i,
	input wire logic sc2_b_i,
	input wire logic sc3_b_i,
	input wire logic sc4_b_i,
	input wire logic rd_nwr_i,
	input wire logic [bprfsm_pkg::DATA_W-1:0] ad_b_i,
	input wire logic bus_rst_b_i,
	input wire logic rstnc_b_i,
	input wire logic buserr_b_i,
	input wire logic timout_b_i,
	input wire logic [2:0] user_err_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	input wire logic [bprfsm_pkg::DATA_W-1:0] rd_data_i,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [bprfsm_pkg::DATA_W-1:0] wr_data_o,
	output logic sc4_b_o,
	output logic [2:0] err_b_o,
	output logic sc8_b_o,
	output logic ctl_oe_o,
	output logic [bprfsm_pkg::DATA_W-1:0] ad_b_o,
	output logic ad_oe_o,
	output logic busy_o
);
	import bprfsm_pkg::*;

	// Write fill counter is one bit wider so a full FIFO can be counted
	localparam int WF_W = $clog2(FIFO_DEPTH) + 1;

	// Full module state in one record
	typedef struct packed {
		bprfsm_state_t st;
		logic [1:0] quiet;
		logic rd;
		logic faulted;
		logic dec_wait;
		logic busy;
		logic [WF_W-1:0] wfill;
		bprfsm_drv_t drv;
	} bprfsm_reg_t;

	bprfsm_reg_t s_r;
	bprfsm_reg_t s_nxt;
	logic rfifo_valid;
	logic [DATA_W-1:0] rfifo_data;
	logic wfifo_ready;
	logic pop_rd;
	logic push_wr;
	logic rep_ready;
	logic match;
	logic eoc_hs;
	logic exc;
	logic wr_acc;
	logic wr_room;

	// Address owned when masked bits equal the base
	function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] m);
		addr_hit = ((a & m) == (b & m));
	endfunction : addr_hit

	// Even parity so SC8..SC4 hold an even count of ones
	function automatic logic even_par(input logic [3:0] v);
		even_par = ^v;
	endfunction : even_par

	// Address lines are active low on the backplane
	assign match = addr_hit(~ad_b_i, addr_base_i, addr_mask_i);
	assign eoc_hs = !sc2_b_i && !sc4_b_i;
	assign exc = !buserr_b_i || !timout_b_i || !bus_rst_b_i || !rstnc_b_i;

	// A write accepted this clock takes a slot, so staying ready needs one more
	assign wr_acc = (s_r.st == BPR_HSHAKE) && !sc3_b_i && !s_r.faulted && !s_r.rd;
	assign wr_room = wfifo_ready && ((s_r.wfill + WF_W'(wr_acc)) < WF_W'(FIFO_DEPTH));
	// Readiness: read needs a word queued; write needs room and SC3 low
	assign rep_ready = s_r.rd ? rfifo_valid : (wr_room && !sc3_b_i);

	// Read FIFO feeds the bus; a word is consumed as it is latched for the handshake
	bprfsm_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rfifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(rd_valid_i),
		.in_ready_o(rd_ready_o),
		.in_data_i(rd_data_i),
		.out_valid_o(rfifo_valid),
		.out_ready_i(pop_rd),
		.out_data_o(rfifo_data)
	);

	// Write FIFO absorbs bus data; a stalled drain stalls the handshake
	bprfsm_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_wfifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(push_wr),
		.in_ready_o(wfifo_ready),
		.in_data_i(~ad_b_i),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(wr_data_o)
	);

	// Next-state and output computation
	always_comb begin
		logic acc;
		logic err_any;
		acc = 1'b0;
		err_any = |user_err_i;
		s_nxt = s_r;
		pop_rd = 1'b0;
		push_wr = 1'b0;
		// Requestor completes its side of this transfer
		acc = (s_r.st == BPR_HSHAKE) && !sc3_b_i;
		case (s_r.st)
			BPR_IDLE: begin
				if (s_r.quiet != 2'h0) begin
					s_nxt.quiet = s_r.quiet - 2'h1;
				end else if (!sc0_b_i) begin
					s_nxt.st = BPR_DECODE;
					s_nxt.rd = rd_nwr_i;
					s_nxt.dec_wait = !match;
				end
			end
			BPR_DECODE: begin
				// Decode is single clock; abort path kept for the end handshake
				if (eoc_hs) begin
					s_nxt.st = BPR_IDLE;
				end else if (s_r.dec_wait) begin
					s_nxt.st = BPR_IDLE;
				end else if (!rep_ready) begin
					s_nxt.st = BPR_HSWAIT;
				end else begin
					s_nxt.st = BPR_HSHAKE;
				end
			end
			BPR_HSWAIT: begin
				if (rep_ready) begin
					s_nxt.st = BPR_HSHAKE;
				end
			end
			BPR_HSHAKE: begin
				if (!sc2_b_i) begin
					s_nxt.st = BPR_IDLE;
				end else if (s_r.faulted) begin
					s_nxt.st = BPR_HSHAKE;
				end else if (acc && !rep_ready) begin
					s_nxt.st = BPR_HSWAIT;
				end else begin
					s_nxt.st = BPR_HSHAKE;
				end
			end
			default: begin
				s_nxt.st = BPR_IDLE;
			end
		endcase
		// Write data moves only on accepted, error-free transfers
		if (acc && !s_r.faulted) begin
			push_wr = !s_r.rd;
		end
		// Drive pattern follows the next state
		s_nxt.drv.ad_oe = 1'b0;
		s_nxt.drv.ctl_oe = 1'b0;
		s_nxt.drv.sc4_b = 1'b1;
		s_nxt.drv.err_b = ERR_NONE;
		s_nxt.drv.sc8_b = 1'b1;
		case (s_nxt.st)
			BPR_HSWAIT: begin
				s_nxt.drv.ctl_oe = 1'b1;
				s_nxt.faulted = 1'b0;
			end
			BPR_HSHAKE: begin
				s_nxt.drv.ctl_oe = 1'b1;
				s_nxt.drv.sc4_b = 1'b0;
				if (s_r.st != BPR_HSHAKE || (acc && !s_r.faulted)) begin
					// New transfer period: load fresh word and error, then hold
					s_nxt.faulted = err_any;
					s_nxt.drv.err_b = ~user_err_i;
					s_nxt.drv.ad_b = s_nxt.rd ? ~rfifo_data : '1;
					// Pop as the word is latched: the head moves a clock later, so a
					// pop on acceptance would resend the same word back to back
					pop_rd = s_nxt.rd && !err_any;
				end else begin
					s_nxt.drv.err_b = s_r.drv.err_b;
					s_nxt.drv.ad_b = s_r.drv.ad_b;
				end
				s_nxt.drv.ad_oe = s_nxt.rd;
				s_nxt.drv.sc8_b = even_par({s_nxt.drv.err_b, 1'b0});
			end
			default: begin
				s_nxt.faulted = 1'b0;
			end
		endcase
		// Exception or bus reset forces and holds idle
		if (exc) begin
			s_nxt.st = BPR_IDLE;
			s_nxt.quiet = QUIET_CLKS;
			s_nxt.faulted = 1'b0;
			s_nxt.drv.ctl_oe = 1'b0;
			s_nxt.drv.ad_oe = 1'b0;
			s_nxt.drv.sc4_b = 1'b1;
			s_nxt.drv.err_b = ERR_NONE;
			s_nxt.drv.sc8_b = 1'b1;
			pop_rd = 1'b0;
			push_wr = 1'b0;
		end
		// Busy and write fill follow the final next state and FIFO traffic
		s_nxt.busy = (s_nxt.st != BPR_IDLE);
		s_nxt.wfill = s_r.wfill + WF_W'(push_wr) - WF_W'(wr_valid_o && wr_ready_i);
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '{st: BPR_IDLE, quiet: QUIET_CLKS, rd: 1'b0, faulted: 1'b0,
				dec_wait: 1'b0, busy: 1'b0, wfill: '0,
				drv: '{sc4_b: 1'b1, err_b: ERR_NONE, sc8_b: 1'b1, ctl_oe: 1'b0,
				ad_b: '1, ad_oe: 1'b0}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sc4_b_o = s_r.drv.sc4_b;
	assign err_b_o = s_r.drv.err_b;
	assign sc8_b_o = s_r.drv.sc8_b;
	assign ctl_oe_o = s_r.drv.ctl_oe;
	assign ad_b_o = s_r.drv.ad_b;
	assign ad_oe_o = s_r.drv.ad_oe;
	assign busy_o = s_r.busy;
endmodule : bprfsm_replier

// file: test/bprfsm_replier_properties.sv
// Purpose: Assertions on the replier's bus-side outputs
// Assumes: Outputs are registered on clk_i
// Notes: Bound into every replier instance
`timescale 1ns/1ps
module bprfsm_checker (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sc2_b_i,
	input wire logic sc3_b_i,
	input wire logic buserr_b_i,
	input wire logic timout_b_i,
	input wire logic sc4_b_o,
	input wire logic [2:0] err_b_o,
	input wire logic sc8_b_o,
	input wire logic ctl_oe_o,
	input wire logic [31:0] ad_b_o,
	input wire logic ad_oe_o,
	input wire logic busy_o
);
	logic ok;
	logic hs;
	// No bus error or timeout on the bus; replier showing its ready
	assign ok = buserr_b_i & timout_b_i;
	assign hs = ctl_oe_o & ~sc4_b_o;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_idle_silent: assert property (!busy_o |-> !ctl_oe_o && !ad_oe_o)
		else $error("drive while idle");
	a_wait_high: assert property (ctl_oe_o && sc4_b_o |-> err_b_o == 3'h7 && sc8_b_o)
		else $error("wait lines low");
	a_even_parity: assert property (hs |-> !(^{sc8_b_o, err_b_o, sc4_b_o}))
		else $error("odd parity");
	a_hs_steady: assert property (hs && sc3_b_i && sc2_b_i && ok |=>
		hs && $stable(err_b_o) && $stable(ad_b_o))
		else $error("handshake moved");
	a_fault_hold: assert property (hs && err_b_o != 3'h7 && sc2_b_i && ok |=> hs)
		else $error("fault released early");
	a_eoc_release: assert property (hs && !sc2_b_i |=> !ctl_oe_o && !ad_oe_o)
		else $error("end of cycle ignored");
	a_exc_idle: assert property (!ok ##1 !ok ##1 !ok |-> !busy_o && !ctl_oe_o)
		else $error("busy in exception");
	a_quiet_gap: assert property ($rose(ok) |=> !busy_o [*3])
		else $error("cycle too soon");
endmodule : bprfsm_checker
bind bprfsm_replier bprfsm_checker u_bprfsm_checker (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.sc2_b_i(sc2_b_i), .sc3_b_i(sc3_b_i), .buserr_b_i(buserr_b_i), .timout_b_i(timout_b_i),
	.sc4_b_o(sc4_b_o), .err_b_o(err_b_o), .sc8_b_o(sc8_b_o), .ctl_oe_o(ctl_oe_o),
	.ad_oe_o(ad_oe_o), .ad_b_o(ad_b_o), .busy_o(busy_o));

// file: test/bprfsm_requestor.sv
// Purpose: Requesting agent model for the replier
// Assumes: Released lines float high by termination
// Notes: Ready at once on writes, after SC4 on reads; ends the cycle after a fault
`timescale 1ns/1ps
module bprfsm_requestor (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic go_i,
	input wire logic rd_i,
	input wire logic [7:0] n_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wseed_i,
	input wire logic sc4_b_i,
	input wire logic [2:0] err_b_i,
	output logic sc0_b_o,
	output logic sc2_b_o,
	output logic sc3_b_o,
	output logic rd_nwr_o,
	output logic [31:0] ad_o,
	output logic busy_o,
	output logic rv_o
);
	logic [1:0] st;
	logic [7:0] k;
	logic done;
	// A transfer ends when both sides show ready on one edge
	assign done = st == 2'h2 && !sc4_b_i && !sc3_b_o;
	assign rv_o = done && rd_nwr_o && err_b_i == 3'h7;
	assign busy_o = st != 2'h0;
	// Exceptions arrive through the reset, holding the model idle
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= 2'h0;
			{sc0_b_o, sc2_b_o, sc3_b_o, rd_nwr_o} <= 4'hf;
			ad_o <= '1;
			k <= 8'h0;
		end else if (st == 2'h0 && go_i) begin
			st <= 2'h1;
			sc0_b_o <= 1'b0;
			ad_o <= ~addr_i;
			rd_nwr_o <= rd_i;
			k <= 8'h0;
		end else if (st == 2'h1) begin
			// Reads wait for the replier's word before SC3 goes low
			st <= rd_nwr_o ? 2'h3 : 2'h2;
			{sc0_b_o, sc3_b_o} <= rd_nwr_o ? 2'h3 : 2'h2;
			sc2_b_o <= rd_nwr_o || n_i != 8'h1;
			ad_o <= rd_nwr_o ? '1 : ~wseed_i;
		end else if (st == 2'h3 && !sc4_b_i) begin
			st <= 2'h2;
			sc3_b_o <= 1'b0;
			sc2_b_o <= n_i != 8'h1;
		end else if (done && !sc2_b_o) begin
			st <= 2'h0;
			{sc2_b_o, sc3_b_o} <= 2'h3;
			ad_o <= '1;
		end else if (done) begin
			k <= k + 8'h1;
			sc2_b_o <= k + 8'h2 != n_i && err_b_i == 3'h7;
			ad_o <= rd_nwr_o ? '1 : ~(wseed_i + 32'(k) + 32'h1);
		end
	end
endmodule : bprfsm_requestor

// file: test/test_bprfsm_replier.sv
// Purpose: Self-checking bench of the replier machine
// Assumes: Requestor model on the bus side
// Notes: Random data from a fixed seed
`timescale 1ns/1ps
module test_bprfsm_replier;
	import bprfsm_pkg::*;
	logic clk_i = 0, rst_b_i = 0, go = 0, rd = 1, rd_valid_i = 0, wr_ready_i = 0;
	logic buserr_b_i = 1, timout_b_i = 1, sc0_b, sc2_b, sc3_b, rd_nwr, pbusy, rv;
	logic rd_ready_o, wr_valid_o, sc4_b_o, sc8_b_o, ctl_oe_o, ad_oe_o, busy_o;
	logic [2:0] user_err_i = 0, err_b_o, seen;
	logic [7:0] n = 1;
	logic [31:0] addr = 0, seed = 0, rd_data_i = 0, wr_data_o, ad_b_o, p_ad, ad_bus;
	logic [31:0] exp_q[$], got_q[$];
	int miscompares = 0, check_count = 0;
	assign ad_bus = ad_oe_o ? ad_b_o : p_ad;
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	bprfsm_replier u_bprfsm_replier (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_base_i(BASE_DEF),
		.addr_mask_i(MASK_DEF), .sc0_b_i(sc0_b), .sc2_b_i(sc2_b), .sc3_b_i(sc3_b),
		.sc4_b_i(sc4_b_o | ~ctl_oe_o), .rd_nwr_i(rd_nwr), .ad_b_i(ad_bus), .bus_rst_b_i(1'b1),
		.rstnc_b_i(1'b1), .buserr_b_i(buserr_b_i), .timout_b_i(timout_b_i),
		.user_err_i(user_err_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o),
		.rd_data_i(rd_data_i), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
		.wr_data_o(wr_data_o), .sc4_b_o(sc4_b_o), .err_b_o(err_b_o), .sc8_b_o(sc8_b_o),
		.ctl_oe_o(ctl_oe_o), .ad_b_o(ad_b_o), .ad_oe_o(ad_oe_o), .busy_o(busy_o));
	bprfsm_requestor u_bprfsm_requestor (.clk_i(clk_i), .rst_b_i(rst_b_i & buserr_b_i & timout_b_i),
		.go_i(go), .rd_i(rd), .n_i(n), .addr_i(addr), .wseed_i(seed), .sc4_b_i(sc4_b_o | ~ctl_oe_o),
		.err_b_i(err_b_o | {3{~ctl_oe_o}}), .sc0_b_o(sc0_b), .sc2_b_o(sc2_b), .sc3_b_o(sc3_b),
		.rd_nwr_o(rd_nwr), .ad_o(p_ad), .busy_o(pbusy), .rv_o(rv));
	// Monitors take pre-edge values; words pushed under a fault are never expected
	always @(posedge clk_i) begin
		if (rd_valid_i && rd_ready_o && user_err_i == 3'h0) exp_q.push_back(rd_data_i);
		if (rv) got_q.push_back(~ad_bus);
		if (wr_valid_o && wr_ready_i) got_q.push_back(wr_data_o);
		if (ctl_oe_o && !sc4_b_o) seen <= err_b_o;
	end
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic go_cyc(logic r, logic [7:0] k, logic [31:0] a);
		rd <= r;
		n <= k;
		addr <= a;
		go <= 1;
		@(posedge clk_i);
		go <= 0;
		@(posedge clk_i);
	endtask : go_cyc
	// Bounded wait for both agents to go idle, then compare words in order
	task automatic fin(string s);
		int t;
		for (t = 0; t < 500 && (pbusy || busy_o); t++)
			@(posedge clk_i);
		if (t == 500) begin
			miscompares++;
			report_and_stop();
		end
		repeat (4) @(posedge clk_i);
		chk("count", exp_q.size(), got_q.size());
		while (exp_q.size() && got_q.size())
			chk("word", exp_q.pop_front(), got_q.pop_front());
		exp_q.delete();
		got_q.delete();
		$display("test %s done", s);
	endtask : fin
	initial begin
		void'($urandom(15));
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1;
		repeat (4) @(posedge clk_i);
		// Overfill the read FIFO; refused words never reach exp_q
		rd_valid_i <= 1;
		repeat (34) begin
			rd_data_i <= $urandom;
			@(posedge clk_i);
		end
		rd_valid_i <= 0;
		@(posedge clk_i);
		chk("depth", 32, exp_q.size());
		go_cyc(1, 32, 32'h40);
		fin("burst");
		go_cyc(1, 3, 32'hfffc);
		repeat (4) @(posedge clk_i);
		chk("waiting", 1, sc4_b_o & ctl_oe_o);
		rd_valid_i <= 1;
		repeat (3) begin
			rd_data_i <= $urandom;
			@(posedge clk_i);
		end
		rd_valid_i <= 0;
		fin("late read");
		// Write with the far side stalled, drained afterwards
		seed <= $urandom;
		go_cyc(0, 3, 32'h0);
		for (int i = 0; i < 3; i++)
			exp_q.push_back(seed + i);
		repeat (9) @(posedge clk_i);
		wr_ready_i <= 1;
		fin("write");
		user_err_i <= 3'h5;
		rd_valid_i <= 1;
		@(posedge clk_i);
		rd_valid_i <= 0;
		go_cyc(1, 3, 32'h100);
		fin("fault");
		chk("error lines", 3'h2, seen);
		user_err_i <= 0;
		// Foreign then owned address, each cut short by a different exception
		for (int e = 0; e < 2; e++) begin
			go_cyc(1, 2, e ? 32'h8 : 32'h1_0000);
			repeat (3) @(posedge clk_i);
			chk("busy", e ? 2'h3 : 2'h0, {busy_o, ctl_oe_o});
			{buserr_b_i, timout_b_i} <= e ? 2'h2 : 2'h1;
			repeat (3) @(posedge clk_i);
			{buserr_b_i, timout_b_i} <= 2'h3;
			repeat (4) @(posedge clk_i);
		end
		$display("test exceptions done");
		report_and_stop();
	end
endmodule : test_bprfsm_replier
